// *** cs3_decimator.sv ***
// Chopped sinc3 decimator: modulator bit stream in, averaged result out (raw filter word with reversal off).
// Assumes modulator bit and sample clock arrive from the analog side
// asynchronously, and a core on mclk drives the register port.
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none

module cs3_decimator #(
    parameter int ACC_W = 34,
    parameter int CNT_W = 11
) (
    input wire logic mclk, // 50 MHz system clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire cs3_pkg::cs3_req_s req, // Register port request
    output logic [31:0] rdata, // Read data, cycle after read strobe
    input wire logic mod_clk_pin, // Modulator sample clock, async
    input wire logic mod_bit_pin, // Modulator comparator bit, async
    output logic in_reverse, // Swap analog input polarity
    output logic data_ready // New result waiting
);

    // ==========================================================
    // Pin synchronisers
    logic [2:0] clk_sync_r;
    logic [1:0] bit_sync_r;
    logic mod_tick;

    // Two flops before use; third flop only for edge detect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_sync_r <= 3'h0;
            bit_sync_r <= 2'h0;
        end else begin
            clk_sync_r <= {clk_sync_r[1:0], mod_clk_pin};
            bit_sync_r <= {bit_sync_r[0], mod_bit_pin};
        end
    end

    assign mod_tick = clk_sync_r[1] & ~clk_sync_r[2];

    // ==========================================================
    // Registers
    logic rev_off_r;
    logic [7:0] dword_r;
    logic restart;
    logic wr_mode, wr_dword, rd_data;

    assign wr_mode = req.wr && (req.addr == cs3_pkg::OFS_MODE);
    assign wr_dword = req.wr && (req.addr == cs3_pkg::OFS_DWORD);
    assign rd_data = req.rd && (req.addr == cs3_pkg::OFS_DATA);
    // Any reprogramming flushes the chain
    assign restart = wr_mode | wr_dword;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rev_off_r <= cs3_pkg::MODE_RESET;
        end else if (wr_mode) begin
            rev_off_r <= req.wdata[cs3_pkg::MODE_REV_OFF_BIT];
        end
    end

    // word reset value; range is software's duty
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dword_r <= cs3_pkg::DWORD_RESET;
        end else if (wr_dword) begin
            dword_r <= req.wdata[7:0];
        end
    end

    // ==========================================================
    // Decimation counter
    logic [CNT_W-1:0] smp_cnt_r;
    logic [CNT_W-1:0] dec_len;
    logic dec_tick;

    assign dec_len = CNT_W'({dword_r, 3'h0});
    assign dec_tick = mod_tick && (smp_cnt_r == dec_len - CNT_W'(1));

    // word 255 gives 2040 samples, the slowest rate
    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            smp_cnt_r <= '0;
        end else if (dec_tick) begin
            smp_cnt_r <= '0;
        end else if (mod_tick) begin
            smp_cnt_r <= smp_cnt_r + CNT_W'(1);
        end
    end

    // ==========================================================
    // Sinc3 integrators and combs
    logic [ACC_W-1:0] integ_r [3];
    logic [ACC_W-1:0] integ_in [3];
    logic [ACC_W-1:0] dly_r [3];
    logic [ACC_W-1:0] comb_w [4];
    logic in_bit;
    logic reverse_r;

    // Flipping the bit undoes the analog swap
    assign in_bit = bit_sync_r[1] ^ reverse_r;
    // Comb takes the integrator's next value so no pre-swap sample leaks in
    assign comb_w[0] = integ_r[2] + integ_in[2];

    // three integrate and three comb stages
    for (genvar k = 0; k < 3; k++) begin : g_stage
        if (k == 0) begin : g_first
            assign integ_in[k] = ACC_W'(in_bit);
        end else begin : g_next
            assign integ_in[k] = integ_r[k-1];
        end
        assign comb_w[k+1] = comb_w[k] - dly_r[k];

        // Wraparound is harmless: combs cancel it modulo 2^ACC_W
        always_ff @(posedge mclk) begin
            if (!rst_n || restart) begin
                integ_r[k] <= '0;
            end else if (mod_tick) begin
                integ_r[k] <= integ_r[k] + integ_in[k];
            end
        end

        always_ff @(posedge mclk) begin
            if (!rst_n || restart) begin
                dly_r[k] <= '0;
            end else if (dec_tick) begin
                dly_r[k] <= comb_w[k];
            end
        end
    end

    // ==========================================================
    // Conversion sequencing
    logic [1:0] phase_r;
    logic [1:0] fill_cnt_r;
    logic [1:0] fill_need;
    logic conv;
    logic publish;

    // chop waits three periods for the filter to flush
    assign conv = dec_tick && (rev_off_r || (phase_r == 2'(cs3_pkg::CHOP_PERIODS - 1)));
    // averager, or sinc history, must refill first
    assign fill_need = rev_off_r ? cs3_pkg::FILL_PLAIN : cs3_pkg::FILL_CHOP;
    assign publish = conv && (fill_cnt_r >= fill_need);

    // Chop phase inside one result
    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            phase_r <= 2'h0;
        end else if (conv) begin
            phase_r <= 2'h0;
        end else if (dec_tick) begin
            phase_r <= phase_r + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            fill_cnt_r <= 2'h0;
        end else if (conv && (fill_cnt_r < fill_need)) begin
            fill_cnt_r <= fill_cnt_r + 2'h1;
        end
    end

    // swap polarity on every chopped result
    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            reverse_r <= 1'b0;
        end else if (conv && !rev_off_r) begin
            reverse_r <= ~reverse_r;
        end
    end

    // ==========================================================
    // Running average and result register
    logic [ACC_W-1:0] prev_r;
    logic [ACC_W:0] sum_w;
    logic [ACC_W-1:0] avg_w;
    logic [ACC_W-1:0] result_w;
    logic [31:0] data_r;
    logic ready_r;

    // two-sample mean; a carry bit keeps the sum exact
    assign sum_w = {1'b0, prev_r} + {1'b0, comb_w[3]};
    assign avg_w = sum_w[ACC_W:1];
    assign result_w = rev_off_r ? comb_w[3] : avg_w;

    // previous word always kept, so a step settles gradually
    always_ff @(posedge mclk) begin
        if (!rst_n || restart) begin
            prev_r <= '0;
        end else if (conv) begin
            prev_r <= comb_w[3];
        end
    end

    // whole word captured in one edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            data_r <= 32'h0;
        end else if (publish) begin
            data_r <= result_w[ACC_W-1 -: 32];
        end
    end

    // Ready is sticky; a new result beats a clearing read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ready_r <= 1'b0;
        end else if (publish) begin
            ready_r <= 1'b1;
        end else if (rd_data) begin
            ready_r <= 1'b0;
        end
    end

    // ==========================================================
    // Read port and outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else if (req.rd) begin
            case (req.addr)
                cs3_pkg::OFS_MODE: rdata <= {31'h0, rev_off_r};
                cs3_pkg::OFS_DWORD: rdata <= {24'h0, dword_r};
                cs3_pkg::OFS_STATUS: rdata <= {30'h0, reverse_r, ready_r};
                cs3_pkg::OFS_DATA: rdata <= data_r;
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end

    // Registered copies so outputs come straight from flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_reverse <= 1'b0;
            data_ready <= 1'b0;
        end else begin
            in_reverse <= reverse_r;
            data_ready <= ready_r;
        end
    end

    // ==========================================================
    // Assertions
    // Checks watch design state only, never the bench's drive
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // independent tick count for the length check
    logic [CNT_W-1:0] chk_ticks_r;
    always_ff @(posedge mclk) begin
        if (!rst_n || restart || dec_tick) begin
            chk_ticks_r <= '0;
        end else if (mod_tick) begin
            chk_ticks_r <= chk_ticks_r + CNT_W'(1);
        end
    end

    chk_mode_reset_val: assert property (
        $rose(rst_n) |-> (!rev_off_r && dword_r == cs3_pkg::DWORD_RESET))
        else $error("mode or word wrong after reset");

    chk_sinc_first_stage: assert property (
        (mod_tick && !restart) |=>
            (integ_r[0] == $past(integ_r[0]) + ACC_W'($past(in_bit))))
        else $error("integrator missed a modulator bit");

    chk_dec_length_ok: assert property (
        (dec_tick && !restart) |=> (smp_cnt_r == '0) ##1 (smp_cnt_r < dec_len))
        else $error("decimation length wrong");

    chk_chop_three_periods: assert property (
        (conv && !rev_off_r) |-> (phase_r == 2'h2))
        else $error("chopped result not on third period");

    chk_reverse_toggles: assert property (
        (conv && !rev_off_r && !restart) |=> (reverse_r != $past(reverse_r)))
        else $error("polarity did not swap");

    chk_average_value: assert property (
        (publish && !rev_off_r) |=> (data_r == $past(avg_w[ACC_W-1 -: 32])))
        else $error("result is not two-sample mean");

    chk_settle_refill: assert property (
        restart |=> (fill_cnt_r == 2'h0 && !publish))
        else $error("result published before refill");

    chk_plain_rate: assert property (
        (rev_off_r && dec_tick) |-> (conv && reverse_r == 1'b0))
        else $error("plain mode skipped a period");

    chk_ready_follows: assert property (
        publish |=> ready_r ##1 data_ready)
        else $error("ready not raised after result");

    chk_dec_boundary_len: assert property (
        dec_tick |-> (chk_ticks_r == CNT_W'({dword_r, 3'h0}) - CNT_W'(1)))
        else $error("decimation boundary at wrong sample count");

    chk_reverse_at_result: assert property (
        (!conv && !restart) |=> $stable(reverse_r))
        else $error("polarity changed between results");

    chk_prev_word_kept: assert property (
        (conv && !restart) |=> (prev_r == $past(comb_w[3])))
        else $error("previous filter word not kept");

    chk_plain_no_average: assert property (
        (publish && rev_off_r) |=> (data_r == $past(comb_w[3][ACC_W-1 -: 32])))
        else $error("plain result is not the raw filter word");

    chk_data_one_update: assert property (
        !publish |=> $stable(data_r))
        else $error("data register changed without a result");

    // Main scenarios the bench should reach
    cov_chop_result: cover property (publish && !rev_off_r);
    cov_plain_result: cover property (publish && rev_off_r);
    cov_reprogram_flush: cover property (restart ##[1:1000] conv);
    cov_ready_race: cover property (publish && rd_data);
    cov_status_read: cover property (req.rd && (req.addr == cs3_pkg::OFS_STATUS) && ready_r);

endmodule : cs3_decimator

`default_nettype wire

// *** cs3_decimator_bench.sv ***
// Self-checking bench for the chopped sinc3 decimator.
// Assumes the cs3_pkg package is compiled first; the bench plays core and modulator.
`default_nettype none

module cs3_decimator_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Stimulus setup
    // Smallest word allowed with reversal keeps conversions short
    localparam int W = 13;
    localparam int N = cs3_pkg::DEC_MULT * W;
    localparam int CONV = cs3_pkg::CHOP_PERIODS * N;
    localparam logic [31:0] FULL = 32'((N * N * N) >> 2);
    localparam logic [31:0] HALF = 32'((N * N * N / 2) >> 2);

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    cs3_pkg::cs3_req_s req = '0;
    logic [31:0] rdata;
    logic mod_clk_pin = 1'b0;
    logic mod_bit_pin = 1'b0;
    logic in_reverse;
    logic data_ready;
    logic [31:0] v;
    int fail_count = 0;
    int checked = 0;

    // 50 MHz system clock
    always #10 mclk = ~mclk;

    cs3_decimator i_cs3_decimator (
        .mclk(mclk),
        .rst_n(rst_n),
        .req(req),
        .rdata(rdata),
        .mod_clk_pin(mod_clk_pin),
        .mod_bit_pin(mod_bit_pin),
        .in_reverse(in_reverse),
        .data_ready(data_ready)
    );

    // ==========================================================
    // Bus and modulator tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge mclk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 v = rdata;
    endtask : rd

    // Bit settles a cycle before the sample edge; edges stay 4+ mclk apart
    task automatic mod_run(input int n, input logic follow);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            mod_bit_pin <= follow ? ~in_reverse : 1'b1;
            @(posedge mclk);
            mod_clk_pin <= 1'b1;
            repeat (4) @(posedge mclk);
            mod_clk_pin <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask : mod_run

    // Covers synchroniser depth plus the registered flags
    task automatic settle();
        repeat (6) @(posedge mclk);
        #1;
    endtask : settle

    task automatic end_sim();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // Watchdog, well past the roughly 18000 cycles the tests need
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        end_sim();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(cs3_pkg::OFS_MODE);
        check(v, 32'h0);
        rd(cs3_pkg::OFS_DWORD);
        check(v, 32'h45);
        check(in_reverse, 32'h0);
        // Chopped, modulator follows the swap: offset-free full scale
        wr(cs3_pkg::OFS_DWORD, 32'(W));
        wr(cs3_pkg::OFS_MODE, 32'h0);
        mod_run(CONV - 1, 1'b1);
        settle();
        check(in_reverse, 32'h0);
        mod_run(1, 1'b1);
        settle();
        check(in_reverse, 32'h1);
        check(data_ready, 32'h0);
        rd(cs3_pkg::OFS_STATUS);
        check(v, 32'h2);
        mod_run(CONV, 1'b1);
        settle();
        check(in_reverse, 32'h0);
        check(data_ready, 32'h1);
        rd(cs3_pkg::OFS_STATUS);
        check(v, 32'h1);
        rd(cs3_pkg::OFS_DATA);
        check(v, FULL);
        settle();
        check(data_ready, 32'h0);
        mod_run(CONV, 1'b1);
        settle();
        check(data_ready, 32'h1);
        rd(cs3_pkg::OFS_DATA);
        check(v, FULL);
        // Chopped, modulator ignores the swap: opposite halves average out
        wr(cs3_pkg::OFS_MODE, 32'h0);
        mod_run(2 * CONV, 1'b0);
        settle();
        check(data_ready, 32'h1);
        rd(cs3_pkg::OFS_DATA);
        check(v, HALF);
        // Reversal off: one result per decimator period after flush
        wr(cs3_pkg::OFS_MODE, 32'h1);
        mod_run(3 * N - 1, 1'b0);
        settle();
        check(data_ready, 32'h0);
        mod_run(1, 1'b0);
        settle();
        check(data_ready, 32'h1);
        check(in_reverse, 32'h0);
        rd(cs3_pkg::OFS_DATA);
        check(v, FULL);
        mod_run(N, 1'b0);
        settle();
        check(data_ready, 32'h1);
        end_sim();
    end

endmodule : cs3_decimator_bench

`default_nettype wire

// *** cs3_pkg.sv ***
// Shared constants and carrier types for the chopped sinc3 decimator.
// Assumes one 50 MHz clock and a plain strobed register port.
`default_nettype none

package cs3_pkg;

    // ==========================================================
    // Register map (word index on the plain register port)
    localparam logic [1:0] OFS_MODE = 2'h0;
    localparam logic [1:0] OFS_DWORD = 2'h1;
    localparam logic [1:0] OFS_STATUS = 2'h2;
    localparam logic [1:0] OFS_DATA = 2'h3;

    // ==========================================================
    // Field positions and reset values
    localparam int MODE_REV_OFF_BIT = 0;
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_REVERSE_BIT = 1;
    localparam logic MODE_RESET = 1'b0;
    localparam logic [7:0] DWORD_RESET = 8'h45;

    // ==========================================================
    // Timing and filter structure
    localparam int MOD_RATE_HZ = 32768;
    localparam int CLK_HZ = 50000000;
    localparam int DEC_MULT = 8;
    localparam int CHOP_PERIODS = 3;
    localparam logic [1:0] FILL_CHOP = 2'h1;
    localparam logic [1:0] FILL_PLAIN = 2'h2;

    // ==========================================================
    // Register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cs3_req_s;

endpackage : cs3_pkg

`default_nettype wire
